// File: design/rrcs_pkg.sv
package rrcs_pkg;

    localparam logic [5:0] RRCS_ADDR_AGC_CTRL0     = 6'h1D;
    localparam logic [5:0] RRCS_ADDR_RSV_A         = 6'h20;
    localparam logic [5:0] RRCS_ADDR_FRONT_END     = 6'h21;
    localparam logic [5:0] RRCS_ADDR_CAL_PUMP      = 6'h23;
    localparam logic [5:0] RRCS_ADDR_CAL_OSC_CUR   = 6'h24;
    localparam logic [5:0] RRCS_ADDR_CAL_COARSE    = 6'h25;
    localparam logic [5:0] RRCS_ADDR_CAL_CTRL      = 6'h26;
    localparam logic [5:0] RRCS_ADDR_RSV_B         = 6'h29;
    localparam logic [5:0] RRCS_ADDR_RSV_C         = 6'h2A;
    localparam logic [5:0] RRCS_ADDR_RSV_D         = 6'h2B;
    localparam logic [5:0] RRCS_ADDR_TEST_TWO      = 6'h2C;
    localparam logic [5:0] RRCS_ADDR_TEST_ONE      = 6'h2D;
    localparam logic [5:0] RRCS_ADDR_TEST_ZERO     = 6'h2E;
    localparam logic [5:0] RRCS_ADDR_PART          = 6'h30;
    localparam logic [5:0] RRCS_ADDR_REVISION      = 6'h31;
    localparam logic [5:0] RRCS_ADDR_FREQ_EST      = 6'h32;
    localparam logic [5:0] RRCS_ADDR_CRC           = 6'h33;
    localparam logic [5:0] RRCS_ADDR_SIGNAL_STRENGTH          = 6'h34;
    localparam logic [5:0] RRCS_ADDR_STATE         = 6'h35;
    localparam logic [5:0] RRCS_ADDR_PKT_STATUS    = 6'h38;
    localparam logic [5:0] RRCS_ADDR_RX_FILL       = 6'h3B;

    localparam logic [7:0] RRCS_RST_AGC_CTRL0      = 8'h91;
    localparam logic [7:0] RRCS_RST_RSV_A          = 8'hF8;
    localparam logic [7:0] RRCS_MASK_RSV_A         = 8'hFB;
    localparam logic [7:0] RRCS_RST_FRONT_END      = 8'h56;
    localparam logic [7:0] RRCS_RST_CAL_PUMP       = 8'hA9;
    localparam logic [7:0] RRCS_RST_CAL_OSC_CUR    = 8'h0A;
    localparam logic [7:0] RRCS_MASK_CAL_OSC_CUR   = 8'h3F;
    localparam logic [7:0] RRCS_RST_CAL_COARSE     = 8'h20;
    localparam logic [7:0] RRCS_MASK_CAL_COARSE    = 8'h3F;
    localparam logic [7:0] RRCS_RST_CAL_CTRL       = 8'h0D;
    localparam logic [7:0] RRCS_MASK_CAL_CTRL      = 8'h7F;
    localparam logic [7:0] RRCS_RST_RSV_B          = 8'h59;
    localparam logic [7:0] RRCS_RST_RSV_C          = 8'h7F;
    localparam logic [7:0] RRCS_RST_RSV_D          = 8'h3F;
    localparam logic [7:0] RRCS_RST_TEST_TWO       = 8'h88;
    localparam logic [7:0] RRCS_KEEP_TEST_TWO      = 8'h81;
    localparam logic [7:0] RRCS_RST_TEST_ONE       = 8'h31;
    localparam logic [7:0] RRCS_KEEP_TEST_ONE      = 8'h35;
    localparam logic [7:0] RRCS_RST_TEST_ZERO      = 8'h0B;

    // field positions
    localparam int RRCS_WAIT_LSB   = 4;
    localparam int RRCS_HOLD_LSB   = 2;
    localparam int RRCS_FLEN_LSB   = 0;
    localparam int RRCS_PUMP_EN_LSB = 4;
    localparam int RRCS_CORE_H_BIT = 5;
    localparam int RRCS_SELCAL_BIT = 1;
    localparam int RRCS_CRC_BIT    = 7;
    localparam int RRCS_CS_BIT     = 6;
    localparam int RRCS_FSTART_BIT = 3;
    localparam int RRCS_GOB_BIT    = 2;
    localparam int RRCS_GOA_BIT    = 0;

    localparam logic [4:0] RRCS_ST_SLEEP    = 5'h00;
    localparam logic [4:0] RRCS_ST_IDLE     = 5'h01;
    localparam logic [4:0] RRCS_ST_CRYSTAL_OFF = 5'h02;
    localparam logic [4:0] RRCS_ST_RX       = 5'h0D;
    localparam logic [4:0] RRCS_ST_RX_END   = 5'h0E;
    localparam logic [4:0] RRCS_ST_RX_RST   = 5'h0F;
    localparam logic [4:0] RRCS_ST_OVERFLOW = 5'h11;

    // discard counts and averaging lengths in channel filter samples; OOK boundary step in dB
    localparam logic [6:0] RRCS_WAIT_UNIT   = 7'h08;
    localparam logic [6:0] RRCS_AVG_BASE    = 7'h08;
    localparam logic [4:0] RRCS_OOK_DB_UNIT = 5'h04;

    typedef enum logic [1:0] {
        RRCS_HOLD_NONE,
        RRCS_HOLD_ON_SYNC,
        RRCS_HOLD_ANALOG,
        RRCS_HOLD_BOTH
    } rrcs_hold_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } rrcs_req_t;

    typedef struct packed {
        logic       cal_done;
        logic [3:0] pump_result;
        logic [4:0] osc_current;
        logic [5:0] coarse;
    } rrcs_cal_t;

    typedef struct packed {
        logic       ook_mode;
        logic [4:0] radio_state;
        logic       wake;
        logic       rx_enter;
        logic       crc_valid;
        logic       crc_match;
        logic       carrier_sense;
        logic       sync_found;
        logic       pkt_end;
        logic       pkt_discard;
        logic       pin_a_raw;
        logic       pin_b_raw;
        logic [7:0] freq_offset;
        logic [7:0] signal_strength;
        logic       rx_overflow;
        logic [6:0] rx_count;
    } rrcs_radio_t;

    typedef struct packed {
        logic [1:0] gain_hold_select;
        logic       osc_select_cal_enable;
        logic       pump_cal_run;
        logic       osc_core_high_select;
        logic [5:0] gain_wait_samples;
        logic [6:0] avg_length;
        logic [4:0] ook_boundary_db;
        logic [7:0] test_two_internal;
        logic [7:0] test_one_internal;
        logic [3:0] pump_current_code;
        logic [4:0] osc_current_code;
        logic [5:0] coarse_code;
    } rrcs_ctrl_t;

endpackage

// File: design/rrcs_regs.sv
`timescale 1ns/1ps
module rrcs_regs #(
    parameter logic [7:0] PART_CODE     = 8'h5A, // arbitrary value
    parameter logic [7:0] REVISION_CODE = 8'h3C  // arbitrary value
) (
    input  wire logic                  mclk,      // system clock
    input  wire logic                  arst_n,    // async reset, active low
    input  wire rrcs_pkg::rrcs_req_t   req,       // register access from spi front end
    output logic [7:0]                 rdata,     // read data, registered
    input  wire logic                  converter_keep_setting, // converter_keep_setting bit
    input  wire rrcs_pkg::rrcs_cal_t   cal,       // synthesizer calibration results
    input  wire rrcs_pkg::rrcs_radio_t radio,     // radio state and status
    output rrcs_pkg::rrcs_ctrl_t       ctrl       // decoded controls to the radio
);
    import rrcs_pkg::*;

    typedef struct packed {
        logic [7:0] agc0;
        logic [7:0] rsv_a;
        logic [7:0] front_end;
        logic [7:0] cal_pump;
        logic [7:0] cal_osc;
        logic [7:0] cal_coarse;
        logic [7:0] cal_ctrl;
        logic [7:0] rsv_b;
        logic [7:0] rsv_c;
        logic [7:0] rsv_d;
        logic [7:0] test_two;
        logic [7:0] test_one;
        logic [7:0] test_zero;
        logic [7:0] test_two_int;
        logic [7:0] test_one_int;
        logic       crc_ok;
        logic       cs;
        logic       fstart;
        logic [7:0] rdata;
    } rrcs_state_t;

    rrcs_state_t s_q;
    rrcs_state_t s_d;

    function automatic logic [7:0] wr_mask(input logic [7:0] old, input logic [7:0] val,
                                            input logic [7:0] mask);
        wr_mask = (val & mask) | (old & ~mask);
    endfunction

    always_comb begin
        s_d       = s_q;
        s_d.rdata = s_q.rdata;

        // wake from sleep: readable copies return to reset, internal copies follow retention
        if (radio.wake) begin
            s_d.rsv_b     = RRCS_RST_RSV_B;
            s_d.rsv_c     = RRCS_RST_RSV_C;
            s_d.rsv_d     = RRCS_RST_RSV_D;
            s_d.test_two  = RRCS_RST_TEST_TWO;
            s_d.test_one  = RRCS_RST_TEST_ONE;
            s_d.test_zero = RRCS_RST_TEST_ZERO;
            s_d.test_two_int = converter_keep_setting ? RRCS_KEEP_TEST_TWO
                                                      : RRCS_RST_TEST_TWO;
            s_d.test_one_int = converter_keep_setting ? RRCS_KEEP_TEST_ONE
                                                      : RRCS_RST_TEST_ONE;
        end

        // calibration results land first so a same-cycle host write overrides them
        if (cal.cal_done) begin
            s_d.cal_pump[3:0]   = cal.pump_result;
            s_d.cal_osc[4:0]    = cal.osc_current;
            s_d.cal_coarse[5:0] = cal.coarse;
        end

        if (req.wr) begin
            case (req.addr)
                RRCS_ADDR_AGC_CTRL0:   s_d.agc0 = req.wdata;
                RRCS_ADDR_RSV_A:       s_d.rsv_a = req.wdata & RRCS_MASK_RSV_A;
                RRCS_ADDR_FRONT_END:   s_d.front_end = req.wdata;
                RRCS_ADDR_CAL_PUMP:    s_d.cal_pump = req.wdata;
                RRCS_ADDR_CAL_OSC_CUR: s_d.cal_osc = req.wdata & RRCS_MASK_CAL_OSC_CUR;
                RRCS_ADDR_CAL_COARSE:  s_d.cal_coarse = req.wdata & RRCS_MASK_CAL_COARSE;
                RRCS_ADDR_CAL_CTRL:    s_d.cal_ctrl = req.wdata & RRCS_MASK_CAL_CTRL;
                RRCS_ADDR_RSV_B:       s_d.rsv_b = req.wdata;
                RRCS_ADDR_RSV_C:       s_d.rsv_c = req.wdata;
                RRCS_ADDR_RSV_D:       s_d.rsv_d = req.wdata;
                RRCS_ADDR_TEST_TWO: begin
                    s_d.test_two     = req.wdata;
                    s_d.test_two_int = req.wdata;
                end
                RRCS_ADDR_TEST_ONE: begin
                    s_d.test_one     = req.wdata;
                    s_d.test_one_int = req.wdata;
                end
                RRCS_ADDR_TEST_ZERO:   s_d.test_zero = req.wdata;
                default: ;
            endcase
        end

        // status flags: for crc_ok and fstart a set in the same cycle as a clear wins; cs is forced clear in idle
        if (radio.rx_enter) begin
            s_d.crc_ok = 1'b0;
        end
        if (radio.crc_valid) begin
            s_d.crc_ok = radio.crc_match;
        end

        if (radio.radio_state == RRCS_ST_IDLE) begin
            s_d.cs = 1'b0;
        end else begin
            s_d.cs = radio.carrier_sense;
        end

        if (radio.pkt_end || radio.pkt_discard ||
            radio.radio_state == RRCS_ST_OVERFLOW) begin
            s_d.fstart = 1'b0;
        end
        if (radio.sync_found) begin
            s_d.fstart = 1'b1;
        end

        // read mux; sleep and crystal-off codes pass through but the host never sees them
        if (req.rd) begin
            case (req.addr)
                RRCS_ADDR_AGC_CTRL0:   s_d.rdata = s_q.agc0;
                RRCS_ADDR_RSV_A:       s_d.rdata = s_q.rsv_a;
                RRCS_ADDR_FRONT_END:   s_d.rdata = s_q.front_end;
                RRCS_ADDR_CAL_PUMP:    s_d.rdata = s_q.cal_pump;
                RRCS_ADDR_CAL_OSC_CUR: s_d.rdata = s_q.cal_osc;
                RRCS_ADDR_CAL_COARSE:  s_d.rdata = s_q.cal_coarse;
                RRCS_ADDR_CAL_CTRL:    s_d.rdata = s_q.cal_ctrl;
                RRCS_ADDR_RSV_B:       s_d.rdata = s_q.rsv_b;
                RRCS_ADDR_RSV_C:       s_d.rdata = s_q.rsv_c;
                RRCS_ADDR_RSV_D:       s_d.rdata = s_q.rsv_d;
                RRCS_ADDR_TEST_TWO:    s_d.rdata = s_q.test_two;
                RRCS_ADDR_TEST_ONE:    s_d.rdata = s_q.test_one;
                RRCS_ADDR_TEST_ZERO:   s_d.rdata = s_q.test_zero;
                RRCS_ADDR_PART:        s_d.rdata = PART_CODE;
                RRCS_ADDR_REVISION:    s_d.rdata = REVISION_CODE;
                RRCS_ADDR_FREQ_EST:
                    s_d.rdata = radio.ook_mode ? 8'h00 : radio.freq_offset;
                RRCS_ADDR_CRC:
                    s_d.rdata = {s_q.crc_ok, 7'h00};
                RRCS_ADDR_SIGNAL_STRENGTH:        s_d.rdata = radio.signal_strength;
                RRCS_ADDR_STATE:       s_d.rdata = {3'h0, radio.radio_state};
                RRCS_ADDR_PKT_STATUS: begin
                    s_d.rdata = 8'h00;
                    s_d.rdata[RRCS_CRC_BIT] = s_q.crc_ok;
                    s_d.rdata[RRCS_CS_BIT]  = s_q.cs;
                    s_d.rdata[RRCS_FSTART_BIT] = s_q.fstart;
                    s_d.rdata[RRCS_GOB_BIT] = radio.pin_b_raw;
                    s_d.rdata[RRCS_GOA_BIT] = radio.pin_a_raw;
                end
                RRCS_ADDR_RX_FILL:
                    s_d.rdata = {radio.rx_overflow, radio.rx_count};
                default:               s_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s_q.agc0         <= RRCS_RST_AGC_CTRL0;
            s_q.rsv_a        <= RRCS_RST_RSV_A;
            s_q.front_end    <= RRCS_RST_FRONT_END;
            s_q.cal_pump     <= RRCS_RST_CAL_PUMP;
            s_q.cal_osc      <= RRCS_RST_CAL_OSC_CUR;
            s_q.cal_coarse   <= RRCS_RST_CAL_COARSE;
            s_q.cal_ctrl     <= RRCS_RST_CAL_CTRL;
            s_q.rsv_b        <= RRCS_RST_RSV_B;
            s_q.rsv_c        <= RRCS_RST_RSV_C;
            s_q.rsv_d        <= RRCS_RST_RSV_D;
            s_q.test_two     <= RRCS_RST_TEST_TWO;
            s_q.test_one     <= RRCS_RST_TEST_ONE;
            s_q.test_zero    <= RRCS_RST_TEST_ZERO;
            s_q.test_two_int <= RRCS_RST_TEST_TWO;
            s_q.test_one_int <= RRCS_RST_TEST_ONE;
            s_q.crc_ok       <= 1'b0;
            s_q.cs           <= 1'b0;
            s_q.fstart       <= 1'b0;
            s_q.rdata        <= 8'h00;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata = s_q.rdata;

    // decoded controls; multiplies kept to small widths
    always_comb begin
        ctrl = '0;
        ctrl.gain_wait_samples = 6'((s_q.agc0[RRCS_WAIT_LSB +: 2] + 3'h1)
                                    * RRCS_WAIT_UNIT);
        ctrl.gain_hold_select  = s_q.agc0[RRCS_HOLD_LSB +: 2];
        ctrl.avg_length        = RRCS_AVG_BASE << s_q.agc0[RRCS_FLEN_LSB +: 2];
        ctrl.ook_boundary_db   = 5'((s_q.agc0[RRCS_FLEN_LSB +: 2] + 3'h1)
                                    * RRCS_OOK_DB_UNIT);
        ctrl.osc_select_cal_enable = s_q.test_zero[RRCS_SELCAL_BIT];
        ctrl.pump_cal_run      = |s_q.cal_pump[RRCS_PUMP_EN_LSB +: 2];
        ctrl.osc_core_high_select = s_q.cal_osc[RRCS_CORE_H_BIT];
        ctrl.test_two_internal = s_q.test_two_int;
        ctrl.test_one_internal = s_q.test_one_int;
        ctrl.pump_current_code = s_q.cal_pump[3:0];
        ctrl.osc_current_code  = s_q.cal_osc[4:0];
        ctrl.coarse_code       = s_q.cal_coarse[5:0];
    end

endmodule

// File: sim/rrcs_host_model.sv
`timescale 1ns/1ps
module rrcs_host_model (
    input  wire logic          mclk,  // clock
    output rrcs_pkg::rrcs_req_t req,   // register access
    input  wire logic [7:0]    rdata  // read data
);
    import rrcs_pkg::*;
    initial req = '0;
    // #1 at the end lets the edge's register updates land before callers look
    task wr(input logic [5:0] a, input logic [7:0] v);
        @(posedge mclk) req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge mclk) req <= '0;
        #1;
    endtask
    task rd(input logic [5:0] a, output logic [7:0] v);
        @(posedge mclk) req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge mclk) req <= '0;
        #1 v = rdata;
    endtask
endmodule

// File: sim/rrcs_regs_properties.sv
`timescale 1ns/1ps
module rrcs_regs_properties #(
    parameter logic [7:0] PART_CODE = 8'h5A // arbitrary value
) (
    input wire logic                  mclk,                   // clock
    input wire logic                  arst_n,                 // async reset, active low
    input wire rrcs_pkg::rrcs_req_t   req,                    // register access
    input wire logic [7:0]            rdata,                  // read data
    input wire logic                  converter_keep_setting, // retention bit
    input wire rrcs_pkg::rrcs_cal_t   cal,                    // calibration results
    input wire rrcs_pkg::rrcs_radio_t radio,                  // radio status
    input wire rrcs_pkg::rrcs_ctrl_t  ctrl                    // decoded controls
);
    import rrcs_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    wait_map_a: assert property (req.wr && req.addr == RRCS_ADDR_AGC_CTRL0 |=>
        ctrl.gain_wait_samples == ({4'h0, $past(req.wdata[5:4])} + 6'h01) << 3)
        else $error("gain wait count wrong");
    hold_map_a: assert property (req.wr && req.addr == RRCS_ADDR_AGC_CTRL0 |=>
        ctrl.gain_hold_select == $past(req.wdata[3:2])) else $error("hold select wrong");
    avg_map_a: assert property (req.wr && req.addr == RRCS_ADDR_AGC_CTRL0 |=>
        ctrl.avg_length == 7'h08 << $past(req.wdata[1:0])) else $error("avg length wrong");
    wake_force_a: assert property (radio.wake && !req.wr |=>
        ctrl.test_two_internal == ($past(converter_keep_setting) ? 8'h81 : 8'h88) &&
        ctrl.test_one_internal == ($past(converter_keep_setting) ? 8'h35 : 8'h31))
        else $error("wake forcing wrong");
    offset_zero_a: assert property (req.rd && req.addr == RRCS_ADDR_FREQ_EST &&
        radio.ook_mode |=> rdata == 8'h00) else $error("offset not zero under ook");
    crc_clear_a: assert property (radio.rx_enter && !radio.crc_valid ##1 !radio.crc_valid
        ##1 (req.rd && req.addr == RRCS_ADDR_CRC && !radio.crc_valid) |=> !rdata[7])
        else $error("crc flag not cleared");
    idle_cs_a: assert property (radio.radio_state == RRCS_ST_IDLE ##1 (req.rd &&
        req.addr == RRCS_ADDR_PKT_STATUS && radio.radio_state == RRCS_ST_IDLE) |=> !rdata[6])
        else $error("carrier sense set in idle");
    frame_start_a: assert property (radio.sync_found ##1 (!radio.pkt_end &&
        !radio.pkt_discard && radio.radio_state != RRCS_ST_OVERFLOW) ##1
        (req.rd && req.addr == RRCS_ADDR_PKT_STATUS) |=> rdata[3])
        else $error("frame start flag not set");
    fill_map_a: assert property (req.rd && req.addr == RRCS_ADDR_RX_FILL |=>
        rdata == {$past(radio.rx_overflow), $past(radio.rx_count)}) else $error("fill wrong");
    part_code_a: assert property (req.rd && req.addr == RRCS_ADDR_PART |=>
        rdata == PART_CODE) else $error("part code wrong");
endmodule
bind rrcs_regs rrcs_regs_properties #(.PART_CODE(PART_CODE)) i_props (.mclk(mclk),
    .arst_n(arst_n), .req(req), .rdata(rdata), .converter_keep_setting(converter_keep_setting),
    .cal(cal), .radio(radio), .ctrl(ctrl));

// File: sim/tb.sv
`timescale 1ns/1ps
module tb;
    import rrcs_pkg::*;
    localparam logic [7:0] P_PART = 8'h6E; // arbitrary value
    localparam logic [7:0] P_REV  = 8'h17; // arbitrary value
    logic        mclk = 1'b0;
    logic        arst_n = 1'b0;
    logic        keep = 1'b0;
    rrcs_req_t   req;
    logic [7:0]  rdata;
    logic [7:0]  d;
    rrcs_cal_t   cal = '0;
    rrcs_radio_t radio = '0;
    rrcs_ctrl_t  ctrl;
    int          n_mismatch = 0;
    int          n_checks = 0;
    logic [5:0]  ra [16] = '{6'h1D, 6'h20, 6'h21, 6'h23, 6'h24, 6'h25, 6'h26, 6'h29,
                             6'h2A, 6'h2B, 6'h2C, 6'h2D, 6'h2E, 6'h30, 6'h31, 6'h22};
    logic [7:0]  rv [16] = '{8'h91, 8'hF8, 8'h56, 8'hA9, 8'h0A, 8'h20, 8'h0D, 8'h59,
                             8'h7F, 8'h3F, 8'h88, 8'h31, 8'h0B, P_PART, P_REV, 8'h00};
    always #5 mclk = ~mclk;
    rrcs_host_model i_host (.mclk(mclk), .req(req), .rdata(rdata));
    rrcs_regs #(.PART_CODE(P_PART), .REVISION_CODE(P_REV)) i_dut (.mclk(mclk),
        .arst_n(arst_n), .req(req), .rdata(rdata), .converter_keep_setting(keep),
        .cal(cal), .radio(radio), .ctrl(ctrl));
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task rc(input logic [5:0] a, input logic [7:0] e);
        i_host.rd(a, d);
        chk(d, e);
    endtask
    task pulse(input rrcs_radio_t m);
        @(posedge mclk) radio <= radio | m;
        @(posedge mclk) radio <= radio & ~m;
    endtask
    task test_done;
        if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        for (int i = 0; i < 16; i++) rc(ra[i], rv[i]);
        chk({7'h0, ctrl.osc_select_cal_enable}, 8'h01);
        chk({7'h0, ctrl.pump_cal_run}, 8'h01);
        chk({7'h0, ctrl.osc_core_high_select}, 8'h00);
        for (int s = 0; s < 4; s++) begin
            i_host.wr(RRCS_ADDR_AGC_CTRL0, {2'b10, 2'(s), 2'(s), 2'(s)});
            chk({2'h0, ctrl.gain_wait_samples}, 8'(8 * (s + 1)));
            chk({6'h0, ctrl.gain_hold_select}, 8'(s));
            chk({1'h0, ctrl.avg_length}, 8'(8 << s));
            chk({3'h0, ctrl.ook_boundary_db}, 8'(4 * (s + 1)));
        end
        i_host.wr(RRCS_ADDR_PART, 8'hFF);
        rc(RRCS_ADDR_PART, P_PART);
        i_host.wr(RRCS_ADDR_CAL_OSC_CUR, 8'hFF);
        rc(RRCS_ADDR_CAL_OSC_CUR, 8'h3F);
        chk({7'h0, ctrl.osc_core_high_select}, 8'h01);
        @(posedge mclk) cal <= '{cal_done: 1'b1, pump_result: 4'h5, osc_current: 5'h13,
                                 coarse: 6'h2B};
        @(posedge mclk) cal.cal_done <= 1'b0;
        rc(RRCS_ADDR_CAL_PUMP, 8'hA5);
        rc(RRCS_ADDR_CAL_OSC_CUR, 8'h33);
        rc(RRCS_ADDR_CAL_COARSE, 8'h2B);
        chk({4'h0, ctrl.pump_current_code}, 8'h05);
        chk({3'h0, ctrl.osc_current_code}, 8'h13);
        chk({2'h0, ctrl.coarse_code}, 8'h2B);
        i_host.wr(RRCS_ADDR_TEST_ZERO, 8'h09);
        chk({7'h0, ctrl.osc_select_cal_enable}, 8'h00);
        i_host.wr(RRCS_ADDR_CAL_PUMP, 8'h85);
        chk({7'h0, ctrl.pump_cal_run}, 8'h00);
        for (int k = 0; k < 2; k++) begin
            i_host.wr(RRCS_ADDR_TEST_TWO, 8'h12);
            @(posedge mclk) keep <= 1'(k);
            radio.wake <= 1'b1;
            @(posedge mclk) radio.wake <= 1'b0;
            #1 chk(ctrl.test_two_internal, k ? 8'h81 : 8'h88);
            chk(ctrl.test_one_internal, k ? 8'h35 : 8'h31);
            rc(RRCS_ADDR_TEST_TWO, 8'h88);
            rc(RRCS_ADDR_TEST_ONE, 8'h31);
        end
        @(posedge mclk) radio <= '{freq_offset: 8'hA5, signal_strength: 8'hC3, radio_state: RRCS_ST_RX,
            rx_overflow: 1'b1, rx_count: 7'h2A, carrier_sense: 1'b1, pin_a_raw: 1'b1,
            default: '0};
        rc(RRCS_ADDR_FREQ_EST, 8'hA5);
        rc(RRCS_ADDR_SIGNAL_STRENGTH, 8'hC3);
        rc(RRCS_ADDR_STATE, 8'h0D);
        rc(RRCS_ADDR_RX_FILL, 8'hAA);
        rc(RRCS_ADDR_PKT_STATUS, 8'h41);
        @(posedge mclk) radio.ook_mode <= 1'b1;
        rc(RRCS_ADDR_FREQ_EST, 8'h00);
        pulse('{crc_valid: 1'b1, crc_match: 1'b1, default: '0});
        rc(RRCS_ADDR_CRC, 8'h80);
        pulse('{rx_enter: 1'b1, default: '0});
        rc(RRCS_ADDR_CRC, 8'h00);
        pulse('{sync_found: 1'b1, default: '0});
        rc(RRCS_ADDR_PKT_STATUS, 8'h49);
        pulse('{pkt_end: 1'b1, default: '0});
        rc(RRCS_ADDR_PKT_STATUS, 8'h41);
        pulse('{sync_found: 1'b1, default: '0});
        @(posedge mclk) radio.radio_state <= RRCS_ST_OVERFLOW;
        rc(RRCS_ADDR_STATE, 8'h11);
        rc(RRCS_ADDR_PKT_STATUS, 8'h41);
        @(posedge mclk) radio.radio_state <= RRCS_ST_IDLE;
        rc(RRCS_ADDR_PKT_STATUS, 8'h01);
        test_done;
    end
    initial begin
        // whole run is under two hundred cycles, so this margin only trips on a hang
        repeat (5000) @(posedge mclk);
        n_mismatch++;
        test_done;
    end
endmodule
